// [include/dsdl_map.vh]
`ifndef DSDL_MAP_VH
`define DSDL_MAP_VH
// =========================================================
// Frame format
// =========================================================
`define DSDL_FRAME_BITS 16
`define DSDL_CNT_W 5
`define DSDL_DATA_W 16
// 12-bit variant: four leading don't-care bits
`define DSDL_PAD_12 4
// 14-bit variant: two leading don't-care bits
`define DSDL_PAD_14 2
// =========================================================
// Timing (core_clk 100 MHz)
// =========================================================
`define DSDL_CLK_PERIOD_NS 10
// Half period of the generated serial clock, in ns
`define DSDL_SCLK_HALF_NS 80
`define DSDL_SCLK_HALF_CYC (`DSDL_SCLK_HALF_NS / `DSDL_CLK_PERIOD_NS)
// Width of the load strobe pulse, in ns
`define DSDL_LOAD_PULSE_NS 100
`define DSDL_LOAD_PULSE_CYC (`DSDL_LOAD_PULSE_NS / `DSDL_CLK_PERIOD_NS)
`define DSDL_TMR_W 8
// Reset value of the frame sync and load strobe pins
`define DSDL_PIN_IDLE 1'b1
`endif

// [verilog/dsdl_chan.v]
`timescale 1ns/1ps
`include "dsdl_map.vh"
// One serial port driver: frames a 16-bit word onto frame sync and data at the shared clock edges
module dsdl_chan (
    core_clk,
    rst_b,
    clk_en,
    start,
    word,
    sclk_rise,
    sclk_fall,
    busy,
    frame_sync_n,
    serial_in,
    done
);
    input wire core_clk;
    input wire rst_b;
    input wire clk_en;
    input wire start;
    input wire [`DSDL_DATA_W-1:0] word;
    input wire sclk_rise;
    input wire sclk_fall;
    output reg busy;
    output reg frame_sync_n;
    output reg serial_in;
    output reg done;

    // Shift register and count of falling edges sent
    reg [`DSDL_DATA_W-1:0] shift_r;
    reg [`DSDL_CNT_W-1:0] cnt_r;

    // =========================================================
    // Frame sequencer
    // =========================================================
    // Bits change on the rising serial edge so they stand stable at the falling one
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            busy <= 1'b0;
            frame_sync_n <= `DSDL_PIN_IDLE;
            serial_in <= 1'b0;
            done <= 1'b0;
            shift_r <= {`DSDL_DATA_W{1'b0}};
            cnt_r <= {`DSDL_CNT_W{1'b0}};
        end else if (clk_en) begin
            done <= 1'b0;
            if (!busy) begin
                // Frame opens on a rising edge, first bit placed with it
                if (start && sclk_rise) begin
                    busy <= 1'b1;
                    frame_sync_n <= 1'b0;
                    serial_in <= word[`DSDL_DATA_W-1];
                    shift_r <= {word[`DSDL_DATA_W-2:0], 1'b0};
                    cnt_r <= {`DSDL_CNT_W{1'b0}};
                end
            end else if (sclk_fall) begin
                // Device samples here; count exactly sixteen edges
                cnt_r <= cnt_r + 1'b1;
                if (cnt_r == `DSDL_FRAME_BITS - 1) begin
                    // Frame closes before any seventeenth edge can occur
                    busy <= 1'b0;
                    frame_sync_n <= `DSDL_PIN_IDLE;
                    done <= 1'b1;
                end
            end else if (sclk_rise) begin
                // Next bit, MSB first
                serial_in <= shift_r[`DSDL_DATA_W-1];
                shift_r <= {shift_r[`DSDL_DATA_W-2:0], 1'b0};
            end
        end
    end
endmodule // dsdl_chan

// [verilog/dsdl_host.v]
`timescale 1ns/1ps
`include "dsdl_map.vh"
module dsdl_host (
    core_clk,
    rst_b,
    clk_en,
    wide_mode,
    auto_load,
    load_a,
    load_b,
    wr_valid_a,
    wr_data_a,
    wr_ready_a,
    wr_valid_b,
    wr_data_b,
    wr_ready_b,
    serial_clock,
    frame_sync_n_chan_a,
    serial_in_chan_a,
    frame_sync_n_chan_b,
    serial_in_chan_b,
    load_strobe_n_chan_a,
    load_strobe_n_chan_b,
    busy
);
    input wire core_clk;
    input wire rst_b;
    input wire clk_en;
    // High selects the 14-bit variant, low the 12-bit one
    input wire wide_mode;
    // High holds both load strobes low permanently
    input wire auto_load;
    // Request a load strobe pulse per channel
    input wire load_a;
    input wire load_b;
    // Sample words, two's complement, right aligned
    input wire wr_valid_a;
    input wire [13:0] wr_data_a;
    output reg wr_ready_a;
    input wire wr_valid_b;
    input wire [13:0] wr_data_b;
    output reg wr_ready_b;
    // Common serial clock drives both channel clock pins
    output reg serial_clock;
    output wire frame_sync_n_chan_a;
    output wire serial_in_chan_a;
    output wire frame_sync_n_chan_b;
    output wire serial_in_chan_b;
    output reg load_strobe_n_chan_a;
    output reg load_strobe_n_chan_b;
    output reg busy;

    // Clock divider
    reg [`DSDL_TMR_W-1:0] div_r;
    reg sclk_rise_r;
    reg sclk_fall_r;
    // Per-channel bundle
    wire [1:0] ch_valid;
    wire [1:0] ch_busy;
    wire [1:0] ch_done;
    wire [1:0] ch_fs;
    wire [1:0] ch_sd;
    wire [1:0] ch_load;
    // Registered ready per channel; a word is taken only with it high
    wire [1:0] ch_ready;
    // Strobe width as a full-width constant, cut to the timer width on use
    localparam [31:0] LOAD_PULSE_CYC = `DSDL_LOAD_PULSE_CYC;
    wire [`DSDL_DATA_W-1:0] ch_word [0:1];
    reg [1:0] pend_r;
    reg [1:0] start_r;
    reg [`DSDL_DATA_W-1:0] word_r [0:1];
    reg [`DSDL_TMR_W-1:0] pulse_r [0:1];

    assign ch_valid = {wr_valid_b, wr_valid_a};
    assign ch_load = {load_b, load_a};
    assign ch_ready = {wr_ready_b, wr_ready_a};
    assign ch_word[0] = wide_mode ? {{`DSDL_PAD_14{1'b0}}, wr_data_a}
                                  : {{`DSDL_PAD_12{1'b0}}, wr_data_a[11:0]};
    assign ch_word[1] = wide_mode ? {{`DSDL_PAD_14{1'b0}}, wr_data_b}
                                  : {{`DSDL_PAD_12{1'b0}}, wr_data_b[11:0]};
    // Pins come straight from the channel flip-flops
    assign frame_sync_n_chan_a = ch_fs[0];
    assign serial_in_chan_a = ch_sd[0];
    assign frame_sync_n_chan_b = ch_fs[1];
    assign serial_in_chan_b = ch_sd[1];

    // =========================================================
    // Serial clock divider
    // =========================================================
    // Free running, so both ports see the same edges; strobes mark edges
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            div_r <= {`DSDL_TMR_W{1'b0}};
            serial_clock <= 1'b0;
            sclk_rise_r <= 1'b0;
            sclk_fall_r <= 1'b0;
        end else if (clk_en) begin
            sclk_rise_r <= 1'b0;
            sclk_fall_r <= 1'b0;
            if (div_r == `DSDL_SCLK_HALF_CYC - 1) begin
                div_r <= {`DSDL_TMR_W{1'b0}};
                serial_clock <= ~serial_clock;
                sclk_rise_r <= ~serial_clock;
                sclk_fall_r <= serial_clock;
            end else begin
                div_r <= div_r + 1'b1;
            end
        end
    end

    // =========================================================
    // Per-channel word intake, framing and load strobe
    // =========================================================
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_ch
            // Serial driver for this port
            dsdl_chan u_chan (
                .core_clk(core_clk),
                .rst_b(rst_b),
                .clk_en(clk_en),
                .start(start_r[g]),
                .word(word_r[g]),
                .sclk_rise(sclk_rise_r),
                .sclk_fall(sclk_fall_r),
                .busy(ch_busy[g]),
                .frame_sync_n(ch_fs[g]),
                .serial_in(ch_sd[g]),
                .done(ch_done[g])
            );

            // Accept a word only when the port is idle
            always @(posedge core_clk or negedge rst_b) begin
                if (!rst_b) begin
                    start_r[g] <= 1'b0;
                    word_r[g] <= {`DSDL_DATA_W{1'b0}};
                end else if (clk_en) begin
                    if (start_r[g] && ch_busy[g]) begin
                        start_r[g] <= 1'b0;
                    end else if (ch_ready[g] && ch_valid[g]) begin
                        // Take follows the handshake, never the raw idle state
                        start_r[g] <= 1'b1;
                        word_r[g] <= ch_word[g];
                    end
                end
            end

            // Load pulse is held off while a frame runs, since a strobe
            // falling mid-transfer would be lost; the request waits.
            always @(posedge core_clk or negedge rst_b) begin
                if (!rst_b) begin
                    pend_r[g] <= 1'b0;
                    pulse_r[g] <= {`DSDL_TMR_W{1'b0}};
                end else if (clk_en) begin
                    if (pulse_r[g] != {`DSDL_TMR_W{1'b0}}) begin
                        pulse_r[g] <= pulse_r[g] - 1'b1;
                        pend_r[g] <= pend_r[g] | ch_load[g];
                    end else if ((pend_r[g] | ch_load[g]) && !auto_load
                                 && !ch_busy[g] && !start_r[g]) begin
                        pend_r[g] <= 1'b0;
                        pulse_r[g] <= LOAD_PULSE_CYC[`DSDL_TMR_W-1:0];
                    end else begin
                        pend_r[g] <= pend_r[g] | ch_load[g];
                    end
                end
            end
        end
    endgenerate

    // =========================================================
    // Pin and status registers
    // =========================================================
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            load_strobe_n_chan_a <= `DSDL_PIN_IDLE;
            load_strobe_n_chan_b <= `DSDL_PIN_IDLE;
            wr_ready_a <= 1'b0;
            wr_ready_b <= 1'b0;
            busy <= 1'b0;
        end else if (clk_en) begin
            // Auto mode holds strobes low: update lands on sixteenth edge
            load_strobe_n_chan_a <= ~(auto_load | (pulse_r[0] != 0));
            load_strobe_n_chan_b <= ~(auto_load | (pulse_r[1] != 0));
            // Ready drops at the take edge so a held valid is not taken twice
            wr_ready_a <= !start_r[0] && !ch_busy[0] && !(wr_ready_a && wr_valid_a);
            wr_ready_b <= !start_r[1] && !ch_busy[1] && !(wr_ready_b && wr_valid_b);
            busy <= |(ch_busy | start_r);
        end
    end
endmodule // dsdl_host

// [bench/dsdl_dev_model.sv]
`timescale 1ns/1ps
// =========================================================
// Behavioural converter channel: serial input latch plus converter latch
// =========================================================
module dsdl_dev_model (
    input wire serial_clock,
    input wire frame_sync_n,
    input wire serial_in,
    input wire load_strobe_n,
    input wire wide,
    output logic [15:0] dac_r,
    output logic [6:0] sw_ctrl
);
    logic [2:0] seg_n; // Offset-binary value of the three data MSBs
    // Three data MSBs drive seven segment switches as a thermometer code
    always_comb begin
        seg_n = (wide ? dac_r[13:11] : dac_r[11:9]) ^ 3'h4;
        sw_ctrl = 7'h7F >> (3'h7 - seg_n);
    end
    logic [15:0] shift_r; // Serial shift stage
    logic [15:0] in_r; // Input latch, never seen at the output directly
    logic [4:0] cnt_r; // Bits taken in this frame
    initial begin
        cnt_r = 5'h10;
        in_r = 16'h0000;
        dac_r = 16'h0000;
    end
    // A new frame restarts the count; two writers are fine in a model
    always @(negedge frame_sync_n) begin
        cnt_r <= 5'h00;
    end
    // Capture on falling edges inside a frame; edges past sixteen are dropped
    always @(negedge serial_clock) begin
        if (!frame_sync_n && cnt_r < 5'h10) begin
            shift_r <= {shift_r[14:0], serial_in};
            cnt_r <= cnt_r + 5'h01;
            if (cnt_r == 5'h0F) begin
                in_r <= {shift_r[14:0], serial_in};
                if (!load_strobe_n) begin
                    dac_r <= {shift_r[14:0], serial_in};
                end
            end
        end
    end
    // A strobe edge mid-word is lost: nothing remembers it
    always @(negedge load_strobe_n) begin
        if (cnt_r == 5'h10) begin
            dac_r <= in_r;
        end
    end
endmodule // dsdl_dev_model

// [bench/dsdl_chk_assertions.sv]
`timescale 1ns/1ps
// =========================================================
// Port checks on the controller
// =========================================================
module dsdl_chk (
    input wire core_clk,
    input wire rst_b,
    input wire wide_mode,
    input wire auto_load,
    input wire wr_valid_a,
    input wire wr_ready_a,
    input wire serial_clock,
    input wire frame_sync_n_chan_a,
    input wire serial_in_chan_a,
    input wire frame_sync_n_chan_b,
    input wire serial_in_chan_b,
    input wire load_strobe_n_chan_a,
    input wire load_strobe_n_chan_b
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    a_fs_on_rise: assert property ($fell(frame_sync_n_chan_a)
        |-> $past(serial_clock) && !$past(serial_clock, 2))
        else $error("frame start off the serial clock rise");
    a_frame_len_a: assert property ($fell(frame_sync_n_chan_a) |-> ##248 $rose(frame_sync_n_chan_a))
        else $error("frame A length wrong");
    a_frame_len_b: assert property ($fell(frame_sync_n_chan_b) |-> ##248 $rose(frame_sync_n_chan_b))
        else $error("frame B length wrong");
    a_data_steady: assert property (!frame_sync_n_chan_a && $fell(serial_clock) |-> $stable(serial_in_chan_a))
        else $error("data moved at sampling edge");
    a_pad_narrow: assert property ($fell(frame_sync_n_chan_a) && !wide_mode |-> ##32 !serial_in_chan_a ##16 !serial_in_chan_a)
        else $error("narrow pad bits not leading");
    a_pad_lead: assert property ($fell(frame_sync_n_chan_b) |-> !serial_in_chan_b ##16 !serial_in_chan_b)
        else $error("pad bits not first");
    a_load_idle: assert property ($fell(load_strobe_n_chan_a) && !auto_load |-> frame_sync_n_chan_a)
        else $error("strobe fell inside a frame");
    a_load_width: assert property ($fell(load_strobe_n_chan_a) && !auto_load
        |-> !load_strobe_n_chan_a[*8] ##1 !load_strobe_n_chan_a ##1 !load_strobe_n_chan_a ##1 load_strobe_n_chan_a)
        else $error("strobe pulse width wrong");
    a_auto_hold: assert property (auto_load && $past(auto_load) && $past(rst_b)
        |-> !load_strobe_n_chan_a && !load_strobe_n_chan_b)
        else $error("strobes not held low");
    a_take_frame: assert property (wr_valid_a && wr_ready_a |-> ##[1:20] $fell(frame_sync_n_chan_a))
        else $error("no frame after take");
endmodule // dsdl_chk
bind dsdl_host dsdl_chk u_dsdl_chk (.core_clk, .rst_b, .wide_mode, .auto_load, .wr_valid_a,
    .wr_ready_a, .serial_clock, .frame_sync_n_chan_a, .serial_in_chan_a, .frame_sync_n_chan_b,
    .serial_in_chan_b, .load_strobe_n_chan_a, .load_strobe_n_chan_b);

// [bench/testbench.sv]
`timescale 1ns/1ps
// =========================================================
// Controller driving two behavioural converter channels
// =========================================================
module testbench;
    logic core_clk, rst_b, wide_mode, auto_load, load_a, load_b, busy, serial_clock;
    logic wr_valid_a, wr_valid_b, wr_ready_a, wr_ready_b;
    logic [13:0] wr_data_a, wr_data_b; // Words offered to each channel
    logic fs_a, si_a, fs_b, si_b, ld_a, ld_b; // Serial lines to the channels
    logic [15:0] dac_a, dac_b; // Converter latches of the models
    logic [6:0] sw_a, sw_b; // Segment switch controls of the models
    int fail_count = 0;
    int comparisons = 0;
    dsdl_host u_dsdl_host (.core_clk, .rst_b, .clk_en(1'b1), .wide_mode, .auto_load, .load_a,
        .load_b, .wr_valid_a, .wr_data_a, .wr_ready_a, .wr_valid_b, .wr_data_b, .wr_ready_b,
        .serial_clock, .frame_sync_n_chan_a(fs_a), .serial_in_chan_a(si_a),
        .frame_sync_n_chan_b(fs_b), .serial_in_chan_b(si_b), .load_strobe_n_chan_a(ld_a),
        .load_strobe_n_chan_b(ld_b), .busy);
    dsdl_dev_model u_dsdl_dev_model_a (.serial_clock, .frame_sync_n(fs_a), .serial_in(si_a),
        .load_strobe_n(ld_a), .wide(wide_mode), .dac_r(dac_a), .sw_ctrl(sw_a));
    dsdl_dev_model u_dsdl_dev_model_b (.serial_clock, .frame_sync_n(fs_b), .serial_in(si_b),
        .load_strobe_n(ld_b), .wide(wide_mode), .dac_r(dac_b), .sw_ctrl(sw_b));
    // 100 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t latch %h expected %h", $time, got, exp);
        end
    endtask
    // Offer words on the masked channels; each valid drops at its own take
    task automatic send(input logic [1:0] m, input logic [13:0] da, input logic [13:0] db);
        int n;
        @(posedge core_clk);
        #1;
        wr_data_a = da;
        wr_data_b = db;
        wr_valid_a = m[0];
        wr_valid_b = m[1];
        // Long enough to wait out a whole frame already running on the port
        for (n = 0; n < 600 && (wr_valid_a || wr_valid_b); n++) begin
            @(posedge core_clk);
            if (wr_ready_a === 1'b1) wr_valid_a <= 1'b0;
            if (wr_ready_b === 1'b1) wr_valid_b <= 1'b0;
        end
        if (wr_valid_a || wr_valid_b) begin
            fail_count++;
            $display("ERROR %0t word never taken", $time);
            #1 {wr_valid_a, wr_valid_b} = 2'b00;
        end
    endtask
    // Bounded wait for idle, then room for the 100 ns strobe
    task automatic wait_idle;
        int n;
        repeat (2) @(posedge core_clk);
        for (n = 0; n < 800 && busy !== 1'b0; n++) @(posedge core_clk);
        repeat (20) @(posedge core_clk);
    endtask
    // Narrow word, load asked after the take but before the frame opens must wait for the frame end
    task automatic t_narrow_queued;
        send(2'b01, 14'h3800, 14'h0000);
        #1 load_a = 1'b1;
        @(posedge core_clk);
        #1 load_a = 1'b0;
        @(posedge fs_a);
        chk(dac_a, 16'h0000);
        wait_idle();
        chk(dac_a, 16'h0800);
        chk({9'h000, sw_a}, 16'h0000);
        chk(dac_b, 16'h0000);
    endtask
    // Wide words with strobes held low, then both ports and a back-to-back word
    task automatic t_wide_auto;
        #1 wide_mode = 1'b1;
        auto_load = 1'b1;
        send(2'b10, 14'h0000, 14'h1FFF);
        wait_idle();
        chk(dac_b, 16'h1FFF);
        chk({9'h000, sw_b}, 16'h007F);
        send(2'b11, 14'h2000, 14'h0001);
        send(2'b01, 14'h3FFF, 14'h0000);
        wait_idle();
        chk(dac_a, 16'h3FFF);
        chk(dac_b, 16'h0001);
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        {rst_b, wide_mode, auto_load, load_a, load_b, wr_valid_a, wr_valid_b} = 7'h00;
        wr_data_a = 14'h0000;
        wr_data_b = 14'h0000;
        repeat (16) @(posedge core_clk);
        #1 rst_b = 1'b1;
        t_narrow_queued();
        t_wide_auto();
        stop_test();
    end
    // Watchdog well past the five frames of the run
    initial begin
        repeat (20000) @(posedge core_clk);
        fail_count++;
        stop_test();
    end
endmodule // testbench
